//--- logic/sic_top.sv
// sensor interface control: status, control, converter steering, timing
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "sic_params.svh"
module sic_top #(
	parameter int CNT_W = 16    // width of the fast capture counter
) (
	input  wire logic                   clk_i,         // 10 MHz core clock
	input  wire logic                   arst_n_i,      // async reset, low
	input  wire logic [`SIC_ADDR_W-1:0] addr_i,        // register index
	input  wire logic [7:0]             wdata_i,       // write data
	input  wire logic                   wr_i,          // write strobe
	input  wire logic                   rd_i,          // read strobe
	output logic      [7:0]             rdata_o,       // read data, next cycle
	input  wire logic                   motion_cmp_i,  // sensor below reference
	input  wire logic                   cap_cmp_i,     // cap comparator trip
	input  wire logic                   volt_cmp_i,    // volt comparator trip
	input  wire logic                   meas_tick_i,   // fast measure clock tick
	input  wire logic                   motion_vec_i,  // motion vector executed
	input  wire logic                   glob_ie_i,     // global irq enable
	input  wire logic                   motion_mask_i, // motion irq mask
	output logic                        motion_irq_o,  // motion irq request
	output logic                        motion_on_o,   // motion unit power
	output logic                        cap_on_o,      // cap unit power
	output logic                        volt_on_o,     // volt unit power
	output logic [2:0]                  cap_chan_o,    // capacitance mux pick
	output logic [1:0]                  charge_cur_o,  // charge current pick
	output logic                        discharge_o,   // discharge switch
	output logic                        pulse_out_o,   // pulse to count2
	output logic                        busy_o         // measurement running
);
	// mode and state
	sic_pkg::sic_stage_e stage;
	sic_pkg::sic_meas_e  meas_reg;

	// register storage
	logic [7:0]       control_reg;      // motion on, stage, start
	logic [7:0]       capctl_reg;       // channel and current
	logic [7:0]       compare_reg;      // count2 compare value
	logic             motion_q_reg;     // previous motion level
	logic             edge_flag_reg;    // sticky rising-edge flag
	logic [7:0]       cnt2_reg;         // converter pulse counter
	logic [CNT_W-1:0] cnt3_reg;         // fast timer
	logic [CNT_W-1:0] capture_reg;      // latched fast count
	logic             trip_q_reg;       // previous comparator level
	logic [2:0]       stretch_reg;      // trip pulse width counter
	logic             pulse_reg;        // registered pulse output

	// decoded helpers
	logic motion_level;
	logic trip;
	logic trip_rise;
	logic go_wr;
	logic stop_wr;
	logic match;

	// byte write decode shared by all writable registers
	function automatic logic hit(input logic [`SIC_ADDR_W-1:0] off);
		hit = wr_i && (addr_i == off);
	endfunction : hit

	assign stage = sic_pkg::sic_stage_e'(control_reg[`SIC_SEL_HI:`SIC_SEL_LO]);

	// motion unit output only valid while enabled
	assign motion_level = control_reg[`SIC_BIT_MON] & motion_cmp_i;

	// steer the converter power; reserved code keeps both off
	assign motion_on_o = control_reg[`SIC_BIT_MON];
	assign cap_on_o  = (stage == sic_pkg::SIC_STAGE_CAP);
	assign volt_on_o = (stage == sic_pkg::SIC_STAGE_VOLT);
	assign cap_chan_o   = capctl_reg[`SIC_CCH_HI:`SIC_CCH_LO];
	assign charge_cur_o = capctl_reg[`SIC_CUR_HI:`SIC_CUR_LO];

	// selector: comparator of the enabled stage only
	always_comb begin
		case (stage)
			sic_pkg::SIC_STAGE_CAP:  trip = cap_cmp_i;
			sic_pkg::SIC_STAGE_VOLT: trip = volt_cmp_i;
			default:                 trip = 1'b0;
		endcase
	end
	assign trip_rise = trip & ~trip_q_reg;

	// discharge follows the shaped trip pulse; fixed width set by SIC_PULSE_CYC
	assign discharge_o = pulse_reg;

	assign go_wr   = hit(`SIC_OFF_CONTROL) & wdata_i[`SIC_BIT_GO];
	assign stop_wr = hit(`SIC_OFF_CONTROL) & ~wdata_i[`SIC_BIT_GO];
	// match on the rising trip that brings count2 up to the compare value;
	// a late test on the stretched pulse would miss trips that stay high
	assign match   = (meas_reg == sic_pkg::SIC_MS_RUN) && trip_rise &&
		(cnt2_reg + 8'h01 >= compare_reg);
	assign busy_o  = (meas_reg == sic_pkg::SIC_MS_RUN);
	assign pulse_out_o = pulse_reg;

	// irq request gated by mask and global enable
	assign motion_irq_o = edge_flag_reg & motion_mask_i & glob_ie_i;

	// control register; start bit drops when measurement completes
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			control_reg <= `SIC_RST_BYTE;
		end else if (hit(`SIC_OFF_CONTROL)) begin
			control_reg <= {4'h0, wdata_i[3:0]};
		end else if (match) begin
			control_reg[`SIC_BIT_GO] <= 1'b0;
		end
	end

	// capacitance control and compare value
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			capctl_reg  <= `SIC_RST_BYTE;
			compare_reg <= `SIC_RST_CMP;
		end else begin
			if (hit(`SIC_OFF_CAPCTL)) begin
				// bit 2 has no function, bits 7..6 reserved
				capctl_reg <= {2'b00, wdata_i[5:3], 1'b0, wdata_i[1:0]};
			end
			if (hit(`SIC_OFF_COMPARE)) begin
				compare_reg <= wdata_i;
			end
		end
	end

	// motion edge flag: hardware set wins over any clear
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			motion_q_reg  <= 1'b0;
			edge_flag_reg <= 1'b0;
		end else begin
			motion_q_reg <= motion_level;
			if (motion_level & ~motion_q_reg) begin
				edge_flag_reg <= 1'b1;
			end else if (motion_vec_i) begin
				edge_flag_reg <= 1'b0;
			end else if (hit(`SIC_OFF_STATUS) && wdata_i[`SIC_BIT_MEDGE]) begin
				edge_flag_reg <= 1'b0;
			end
		end
	end

	// pulse shaper: each trip gives one fixed-width pulse, so short volt
	// trips are never missed by the counter
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			trip_q_reg  <= 1'b0;
			stretch_reg <= 3'h0;
			pulse_reg   <= 1'b0;
		end else begin
			trip_q_reg <= trip;
			if (trip_rise) begin
				stretch_reg <= 3'(`SIC_PULSE_CYC);
				pulse_reg   <= 1'b1;
			end else if (stretch_reg > 3'h1) begin
				stretch_reg <= stretch_reg - 3'h1;
			end else begin
				stretch_reg <= 3'h0;
				pulse_reg   <= 1'b0;
			end
		end
	end

	// measurement sequencer
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meas_reg <= sic_pkg::SIC_MS_IDLE;
		end else begin
			case (meas_reg)
				sic_pkg::SIC_MS_IDLE: begin
					if (go_wr) begin
						meas_reg <= sic_pkg::SIC_MS_RUN;
					end
				end
				sic_pkg::SIC_MS_RUN: begin
					if (stop_wr) begin
						meas_reg <= sic_pkg::SIC_MS_IDLE;
					end else if (match) begin
						meas_reg <= sic_pkg::SIC_MS_DONE;
					end
				end
				sic_pkg::SIC_MS_DONE: begin
					if (go_wr) begin
						meas_reg <= sic_pkg::SIC_MS_RUN;
					end else if (stop_wr) begin
						meas_reg <= sic_pkg::SIC_MS_IDLE;
					end
				end
				default: meas_reg <= sic_pkg::SIC_MS_IDLE;
			endcase
		end
	end

	// count2 counts rising trip edges; count3 counts fast ticks, both from start
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt2_reg <= 8'h00;
			cnt3_reg <= `SIC_RST_CNT;
		end else if (go_wr && meas_reg != sic_pkg::SIC_MS_RUN) begin
			cnt2_reg <= 8'h00;
			cnt3_reg <= `SIC_RST_CNT;
		end else if (meas_reg == sic_pkg::SIC_MS_RUN && !match) begin
			if (trip_rise) begin
				cnt2_reg <= cnt2_reg + 8'h01;
			end
			if (meas_tick_i) begin
				cnt3_reg <= cnt3_reg + CNT_W'(1);
			end
		end
	end

	// capture of the fast count on compare match
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			capture_reg <= `SIC_RST_CNT;
		end else if (match) begin
			capture_reg <= cnt3_reg;
		end
	end

	// read port, data one cycle after the strobe
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= `SIC_RST_BYTE;
		end else if (rd_i) begin
			case (addr_i)
				`SIC_OFF_STATUS:
					rdata_o <= {6'h00, motion_level, edge_flag_reg};
				`SIC_OFF_CONTROL:    rdata_o <= control_reg;
				`SIC_OFF_CAPCTL:     rdata_o <= capctl_reg;
				`SIC_OFF_COMPARE:    rdata_o <= compare_reg;
				`SIC_OFF_CAPTURE_LO: rdata_o <= capture_reg[7:0];
				`SIC_OFF_CAPTURE_HI: rdata_o <= 8'(capture_reg >> 8);
				`SIC_OFF_MEASSTAT:   rdata_o <= {6'h00, meas_reg};
				default:             rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end
endmodule : sic_top
`default_nettype wire

//--- logic/sic_params.svh
// register offsets, field positions, reset values and timing constants
`ifndef SIC_PARAMS_SVH
`define SIC_PARAMS_SVH
`define SIC_ADDR_W          4
`define SIC_OFF_STATUS      4'h0
`define SIC_OFF_CONTROL     4'h1
`define SIC_OFF_CAPCTL      4'h2
`define SIC_OFF_COMPARE     4'h3
`define SIC_OFF_CAPTURE_LO  4'h4
`define SIC_OFF_CAPTURE_HI  4'h5
`define SIC_OFF_MEASSTAT    4'h6
`define SIC_BIT_MLEVEL      1
`define SIC_BIT_MEDGE       0
`define SIC_BIT_MON         3
`define SIC_SEL_HI          2
`define SIC_SEL_LO          1
`define SIC_BIT_GO          0
`define SIC_CCH_HI          5
`define SIC_CCH_LO          3
`define SIC_CUR_HI          1
`define SIC_CUR_LO          0
`define SIC_RST_BYTE        8'h00
`define SIC_RST_CMP         8'h01
`define SIC_RST_CNT         16'h0000
`define SIC_PULSE_NS        200
`define SIC_CLK_NS          100
`define SIC_PULSE_CYC       ((`SIC_PULSE_NS + `SIC_CLK_NS - 1) / `SIC_CLK_NS)
`endif

//--- logic/sic_pkg.sv
// types shared by the sensor interface control block
package sic_pkg;
	typedef enum logic [1:0] {
		SIC_STAGE_OFF  = 2'b00,
		SIC_STAGE_CAP  = 2'b01,
		SIC_STAGE_RSVD = 2'b10,
		SIC_STAGE_VOLT = 2'b11
	} sic_stage_e;
	typedef enum logic [1:0] {
		SIC_MS_IDLE = 2'b00,
		SIC_MS_RUN  = 2'b01,
		SIC_MS_DONE = 2'b10
	} sic_meas_e;
endpackage : sic_pkg

//--- dv/sic_assertions.sv
// port-level checks for the sensor interface control block
`timescale 1ns/10ps
`default_nettype none
`include "sic_params.svh"
module sic_assertions (
	input wire logic       clk_i,         // core clock
	input wire logic       arst_n_i,      // async reset, low
	input wire logic [3:0] addr_i,        // register index
	input wire logic [7:0] wdata_i,       // write data
	input wire logic       wr_i,          // write strobe
	input wire logic       rd_i,          // read strobe
	input wire logic [7:0] rdata_o,       // read data
	input wire logic       motion_cmp_i,  // motion comparator
	input wire logic       glob_ie_i,     // global irq enable
	input wire logic       motion_mask_i, // motion irq mask
	input wire logic       motion_irq_o,  // motion irq
	input wire logic       motion_on_o,   // motion unit power
	input wire logic       cap_on_o,      // cap unit power
	input wire logic       volt_on_o,     // volt unit power
	input wire logic [2:0] cap_chan_o,    // cap mux pick
	input wire logic [1:0] charge_cur_o,  // charge current pick
	input wire logic       pulse_out_o,   // pulse to count2
	input wire logic       busy_o         // measurement running
);
	localparam logic [3:0] CT = `SIC_OFF_CONTROL; // control index
	localparam logic [3:0] CC = `SIC_OFF_CAPCTL;  // cap control index
	localparam logic [3:0] ST = `SIC_OFF_STATUS;  // status index
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// irq only with both enables up
	chk_irq_gate: assert property (motion_irq_o |-> glob_ie_i && motion_mask_i)
		else $error("irq raised without enables");
	// stage code 01 drives the cap unit, 11 the volt unit, off and reserved codes none
	chk_stage_write: assert property ($past(wr_i && addr_i == CT) |->
		cap_on_o == ($past(wdata_i[2:1]) == 2'b01) && motion_on_o == $past(wdata_i[3])
		&& volt_on_o == ($past(wdata_i[2:1]) == 2'b11)) else $error("stage decode wrong");
	chk_capctl_write: assert property ($past(wr_i && addr_i == CC) |->
		{cap_chan_o, charge_cur_o} == {$past(wdata_i[5:3]), $past(wdata_i[1:0])})
		else $error("cap control routing wrong");
	// level bit is live, reserved bits zero
	chk_status_read: assert property ($past(rd_i && addr_i == ST) |->
		rdata_o[7:2] == 6'h00 && rdata_o[1] == $past(motion_cmp_i && motion_on_o))
		else $error("status read wrong");
	chk_ctl_resv: assert property ($past(rd_i && addr_i == CT) |-> rdata_o[7:4] == 4'h0)
		else $error("control reserved bits set");
	// shaped pulse lasts two cycles so count2 cannot miss it
	chk_pulse_width: assert property ($rose(pulse_out_o) |=> pulse_out_o || !busy_o)
		else $error("pulse too short");
	chk_pulse_src: assert property ($rose(pulse_out_o) |-> $past(cap_on_o || volt_on_o))
		else $error("pulse with no converter on");
	chk_go_start: assert property ($past(wr_i && addr_i == CT && wdata_i[0] && wdata_i[1]
		&& !busy_o) |-> busy_o) else $error("start did not run");
	chk_stop_idle: assert property ($past(wr_i && addr_i == CT && !wdata_i[0]) |-> ##[0:1] !busy_o)
		else $error("stop did not halt");
endmodule : sic_assertions
bind sic_top sic_assertions u_chk (.clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i,
	.rd_i, .rdata_o, .motion_cmp_i, .glob_ie_i, .motion_mask_i, .motion_irq_o,
	.motion_on_o, .cap_on_o, .volt_on_o, .cap_chan_o, .charge_cur_o,
	.pulse_out_o, .busy_o);
`default_nettype wire

//--- dv/sic_sensor_model.sv
// comparator model of the charge ramp behind both converters
`timescale 1ns/10ps
`default_nettype none
module sic_sensor_model (
	input  wire logic       clk_i,      // core clock
	input  wire logic       arst_n_i,   // async reset, low
	input  wire logic       cap_on_i,   // cap unit powered
	input  wire logic       volt_on_i,  // volt unit powered
	input  wire logic       dis_i,      // discharge switch
	input  wire logic [3:0] ramp_i,     // charge cycles to trip
	output logic            cap_cmp_o,  // cap comparator
	output logic            volt_cmp_o  // volt comparator
);
	logic [3:0] lvl_reg; // charge level in cycles
	// ramp while powered, dump on discharge
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) lvl_reg <= 4'h0;
		else if (dis_i || !(cap_on_i || volt_on_i)) lvl_reg <= 4'h0;
		else if (lvl_reg < ramp_i) lvl_reg <= lvl_reg + 4'h1;
	end
	// unpowered comparator stays low
	assign cap_cmp_o  = cap_on_i && lvl_reg >= ramp_i;
	assign volt_cmp_o = volt_on_i && lvl_reg >= ramp_i;
endmodule : sic_sensor_model
`default_nettype wire

//--- dv/sic_top_tb_top.sv
// self-checking bench for the sensor interface control block
`timescale 1ns/10ps
`default_nettype none
`include "sic_params.svh"
module sic_top_tb_top;
	logic clk_i, arst_n_i, wr_i, rd_i, motion_cmp_i, cap_cmp_i, volt_cmp_i;
	logic meas_tick_i, motion_vec_i, glob_ie_i, motion_mask_i, motion_irq_o;
	logic motion_on_o, cap_on_o, volt_on_o, discharge_o, pulse_out_o, busy_o;
	logic [3:0]  addr_i, ramp;        // index, model ramp
	logic [7:0]  wdata_i, rdata_o, d; // bus data, scratch
	logic [7:0]  pc;                  // pulses seen in a run
	logic [2:0]  cap_chan_o;          // cap mux pick
	logic [1:0]  charge_cur_o;        // current pick
	logic [15:0] cap;                 // captured count
	logic [31:0] seed = 32'h2761AB3F; // xorshift state
	int          fail_count, tests_run, t; // counters, ticks
	localparam logic [3:0] ST = `SIC_OFF_STATUS, CT = `SIC_OFF_CONTROL;
	localparam logic [3:0] CC = `SIC_OFF_CAPCTL, CM = `SIC_OFF_COMPARE;
	sic_top DUT (.clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.motion_cmp_i, .cap_cmp_i, .volt_cmp_i, .meas_tick_i, .motion_vec_i,
		.glob_ie_i, .motion_mask_i, .motion_irq_o, .motion_on_o, .cap_on_o,
		.volt_on_o, .cap_chan_o, .charge_cur_o, .discharge_o, .pulse_out_o,
		.busy_o);
	sic_sensor_model u_sens (.clk_i, .arst_n_i, .cap_on_i(cap_on_o),
		.volt_on_i(volt_on_o), .dis_i(discharge_o), .ramp_i(ramp),
		.cap_cmp_o(cap_cmp_i), .volt_cmp_o(volt_cmp_i));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// readback mask: reserved bits vanish
	function automatic logic [7:0] rmask(logic [3:0] a, logic [7:0] v);
		return (a == CT) ? (v & 8'h0F) : (v & 8'h3B);
	endfunction : rmask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_i);
		{addr_i, wdata_i, wr_i} <= {a, v, 1'b1};
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	// read data valid only in the cycle after the strobe
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_i);
		{addr_i, rd_i} <= {a, 1'b1};
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
		chk({8'h00, d}, {8'h00, e});
	endtask : rchk
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	// bounded wait for run end, counting ticks and pulses
	task automatic wait_run(output int tk, output logic [7:0] p);
		logic prev;
		logic tick;
		tk = 0;
		p = 8'h00;
		prev = 1'b0;
		tick = 1'b0;
		#1;
		for (int i = 0; i < 3000 && busy_o !== 1'b0; i++) begin
			tick = meas_tick_i;
			@(posedge clk_i);
			#1 p += {7'h00, pulse_out_o && !prev};
			prev = pulse_out_o;
			// the match edge itself adds no tick to the capture
			if (busy_o === 1'b1) tk += int'(tick);
		end
		if (busy_o !== 1'b0) begin
			fail_count++;
			give_verdict();
		end
	endtask : wait_run
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// random fast-clock ticks
	always @(posedge clk_i) meas_tick_i <= ^xs();
	initial begin
		{arst_n_i, wr_i, rd_i, motion_cmp_i, motion_vec_i} = 5'h00;
		{glob_ie_i, motion_mask_i, meas_tick_i, addr_i, wdata_i} = 15'h0000;
		ramp = 4'h1;
		repeat (20) @(posedge clk_i);
		arst_n_i <= 1'b1;
		for (int a = 0; a < 8; a++) rchk(4'(a), (a == 3) ? 8'h01 : 8'h00);
		wr(4'hF, 8'hFF);
		rchk(4'hF, 8'h00);
		$display("reset values done");
		for (int k = 0; k < 8; k++) begin
			wr(CT, (8'(xs()) & 8'hF8) | {5'h00, 2'(k), 1'b0});
			rchk(CT, rmask(CT, wdata_i));
			chk({cap_on_o, volt_on_o}, {wdata_i[2:1] == 2'b01, wdata_i[2:1] == 2'b11});
			wr(CC, 8'(xs()));
			rchk(CC, rmask(CC, wdata_i));
			chk({cap_chan_o, charge_cur_o}, {wdata_i[5:3], wdata_i[1:0]});
		end
		$display("register fields done");
		wr(CT, 8'h08);
		motion_cmp_i <= 1'b1;
		rchk(ST, 8'h03);
		{glob_ie_i, motion_mask_i} <= 2'b11;
		@(posedge clk_i);
		#1 chk(motion_irq_o, 1'b1);
		motion_mask_i <= 1'b0;
		@(posedge clk_i);
		#1 chk(motion_irq_o, 1'b0);
		motion_cmp_i <= 1'b0;
		wr(ST, 8'hFE);
		rchk(ST, 8'h01);
		wr(ST, 8'h01);
		rchk(ST, 8'h00);
		motion_cmp_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		motion_vec_i <= 1'b1;
		@(posedge clk_i);
		motion_vec_i <= 1'b0;
		rchk(ST, 8'h02);
		wr(CT, 8'h00);
		rchk(ST, 8'h00);
		$display("motion status done");
		for (int k = 0; k < 6; k++) begin
			// stage off between runs, small compare keeps count3 in range
			ramp = 4'h1 + 4'(xs() & 3);
			wr(CT, 8'h00);
			wr(CM, 8'h02 + 8'(xs() & 3));
			d = wdata_i;
			wr(CT, k[0] ? 8'h07 : 8'h03);
			wait_run(t, pc);
			chk({8'h00, pc}, {8'h00, d});
			cap = 16'(t);
			rchk(`SIC_OFF_CAPTURE_LO, cap[7:0]);
			rchk(`SIC_OFF_CAPTURE_HI, cap[15:8]);
		end
		$display("conversions done");
		give_verdict();
	end
endmodule : sic_top_tb_top
`default_nettype wire
